// [rtl/efr_embedded_function_regs.sv]
// Embedded function register bank: pedometer flags, init requests,
// decision-tree results, rate selects and the paged window to page 0.
// Assumes a byte-wide register port synchronous to clock, and algorithm
// results presented with a one-cycle update strobe.

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Writing one to clear bit zeroes step counter
// - Read-only flag shows a step was detected
// - Read-only flag shows step in delta window
// - Overflow flag sets when count reaches 65536
// - Increment flag, forced low with window programmed
// - First init register holds four request bits
// - Second init register holds two request bits
// - Four read-only decision tree result bytes
// - Normal state-program rates 12.5 to 800 Hz
// - Biopotential state-program rates 50 to 1600 Hz
// - Normal classifier rates 12.5 to 200 Hz
// - Biopotential classifier rates 50 to 1600 Hz
// - 1600 Hz only with high performance off
// - Page 0 reachable only with page zero
// - Page 0 loaded when embedded features enabled
// - Factory values restored at every power-up
// - Addressed page byte returned in value register
// - Page address advances after each value transfer
module efr_embedded_function_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic embedded_features_on,
  input wire logic high_perf_select,
  input wire logic biopotential_only,
  input wire logic algo_update,
  input wire logic step_detected_in,
  input wire logic window_stride_in,
  input wire logic stride_count_incr_in,
  input wire logic [31:0] tree_output_in,
  output logic [efr_pkg::STEP_COUNT_W-1:0] step_count,
  output logic feature_bank_open,
  output logic early_classifier_reinit,
  output logic significant_motion_reinit,
  output logic tilt_reinit,
  output logic stride_algo_reinit,
  output logic late_classifier_reinit,
  output logic state_program_reinit,
  output logic [15:0] state_program_rate_dhz,
  output logic [15:0] classifier_rate_dhz,
  output logic [efr_pkg::PAGE0_COUNT*8-1:0] feature_config
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [efr_pkg::STEP_COUNT_W:0] step_cnt;
  logic [efr_pkg::STEP_COUNT_W:0] next_step_cnt;
  logic clear_bit;
  logic next_clear_bit;
  logic detect_flag;
  logic next_detect_flag;
  logic window_flag;
  logic next_window_flag;
  logic incr_flag;
  logic next_incr_flag;
  logic [7:0] init_a;
  logic [7:0] next_init_a;
  logic [7:0] init_b;
  logic [7:0] next_init_b;
  logic [31:0] trees;
  logic [31:0] next_trees;
  logic [7:0] sm_rate;
  logic [7:0] next_sm_rate;
  logic [7:0] cl_rate;
  logic [7:0] next_cl_rate;
  logic [7:0] page_sel;
  logic [7:0] next_page_sel;
  logic [7:0] page_addr;
  logic [7:0] next_page_addr;
  logic [7:0] page_mode;
  logic [7:0] next_page_mode;
  logic [7:0] bank_gate;
  logic [7:0] next_bank_gate;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic enable_seen;
  logic next_enable_seen;

  logic bank_open;
  logic page_ok;
  logic page_wr;
  logic page_rd;
  logic page_load;
  logic clear_wr;
  logic window_set;
  logic [7:0] page_rdata;
  logic [7:0] src_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = reg_write && bank_open && (reg_addr == ofs);
  endfunction

  // Zero means reserved or not available in this configuration
  function automatic logic [15:0] rate_dhz(input logic [2:0] code,
                                           input logic [2:0] normal_max,
                                           input logic bio,
                                           input logic hp);
    rate_dhz = 16'h0000;
    if (!bio) begin
      if (code <= normal_max) begin
        rate_dhz = efr_pkg::NORMAL_BASE_DHZ << code;
      end
    end else if (code < efr_pkg::BIO_TOP_CODE) begin
      rate_dhz = efr_pkg::BIO_BASE_DHZ << code;
    end else if (code == efr_pkg::BIO_TOP_CODE && !hp) begin
      rate_dhz = efr_pkg::BIO_BASE_DHZ << code;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Access qualification
  assign bank_open = bank_gate[efr_pkg::BANK_OPEN_BIT];
  assign page_ok = bank_open && embedded_features_on
                   && (page_sel[3:0] == efr_pkg::PAGE_ZERO);
  assign page_wr = reg_write && (reg_addr == efr_pkg::OFS_PAGE_VALUE) && page_ok
                   && page_mode[efr_pkg::MODE_WRITE_BIT];
  assign page_rd = reg_read && bank_open && page_ok
                   && (reg_addr == efr_pkg::OFS_PAGE_VALUE)
                   && page_mode[efr_pkg::MODE_READ_BIT];
  // Reload on each enable so stale edits never survive a restart
  assign page_load = embedded_features_on && !enable_seen;
  assign clear_wr = reg_write && bank_open && (reg_addr == efr_pkg::OFS_EVENT_SOURCE)
                    && reg_wdata[efr_pkg::SRC_CLEAR_BIT];
  assign window_set = (feature_config[efr_pkg::PAGE0_WINDOW_HI*8 +: 8] != 8'h00)
                      || (feature_config[efr_pkg::PAGE0_WINDOW_LO*8 +: 8] != 8'h00);

  efr_page0_store u_page0 (
    .clock(clock),
    .reset_n(reset_n),
    .load(page_load),
    .wr_en(page_wr),
    .addr(page_addr),
    .wdata(reg_wdata),
    .rdata(page_rdata),
    .config_flat(feature_config)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pedometer source
  always_comb begin
    next_step_cnt = step_cnt;
    next_clear_bit = clear_bit;
    next_detect_flag = detect_flag;
    next_window_flag = window_flag;
    next_incr_flag = incr_flag;
    if (wr_to(efr_pkg::OFS_EVENT_SOURCE)) begin
      next_clear_bit = reg_wdata[efr_pkg::SRC_CLEAR_BIT];
    end
    if (algo_update) begin
      next_detect_flag = step_detected_in;
      next_window_flag = window_stride_in;
      next_incr_flag = stride_count_incr_in && !window_set;
      if (stride_count_incr_in && !step_cnt[efr_pkg::STEP_COUNT_W]) begin
        next_step_cnt = step_cnt + 1'b1;
      end
    end
    if (window_set) begin
      next_incr_flag = 1'b0;
    end
    // A clear in the same cycle as a new step discards that step
    if (clear_wr) begin
      next_step_cnt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      step_cnt <= '0;
      clear_bit <= 1'b0;
      detect_flag <= 1'b0;
      window_flag <= 1'b0;
      incr_flag <= 1'b0;
    end else begin
      step_cnt <= next_step_cnt;
      clear_bit <= next_clear_bit;
      detect_flag <= next_detect_flag;
      window_flag <= next_window_flag;
      incr_flag <= next_incr_flag;
    end
  end

  always_comb begin
    src_view = 8'h00;
    src_view[efr_pkg::SRC_CLEAR_BIT] = clear_bit;
    src_view[efr_pkg::SRC_DETECT_BIT] = detect_flag;
    src_view[efr_pkg::SRC_WINDOW_BIT] = window_flag;
    src_view[efr_pkg::SRC_OVF_BIT] = step_cnt[efr_pkg::STEP_COUNT_W];
    src_view[efr_pkg::SRC_INCR_BIT] = incr_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration, init requests and tree results
  always_comb begin
    next_init_a = init_a;
    next_init_b = init_b;
    next_trees = trees;
    next_sm_rate = sm_rate;
    next_cl_rate = cl_rate;
    next_page_sel = page_sel;
    next_page_mode = page_mode;
    next_bank_gate = bank_gate;
    next_page_addr = page_addr;
    // Unnamed bits are dropped rather than stored
    if (wr_to(efr_pkg::OFS_INIT_A)) begin
      next_init_a = reg_wdata & efr_pkg::INIT_A_MASK;
    end
    if (wr_to(efr_pkg::OFS_INIT_B)) begin
      next_init_b = reg_wdata & efr_pkg::INIT_B_MASK;
    end
    if (algo_update) begin
      next_trees = tree_output_in;
    end
    if (wr_to(efr_pkg::OFS_SM_RATE)) begin
      next_sm_rate = reg_wdata & efr_pkg::SM_RATE_MASK;
    end
    if (wr_to(efr_pkg::OFS_CL_RATE)) begin
      next_cl_rate = reg_wdata & efr_pkg::CL_RATE_MASK;
    end
    if (wr_to(efr_pkg::OFS_PAGE_SELECT)) begin
      next_page_sel = reg_wdata & efr_pkg::PAGE_SEL_MASK;
    end
    if (wr_to(efr_pkg::OFS_PAGE_MODE)) begin
      next_page_mode = reg_wdata & efr_pkg::PAGE_MODE_MASK;
    end
    if (reg_write && reg_addr == efr_pkg::OFS_BANK_GATE) begin
      next_bank_gate = reg_wdata & efr_pkg::BANK_GATE_MASK;
    end
    if (wr_to(efr_pkg::OFS_PAGE_ADDRESS)) begin
      next_page_addr = reg_wdata;
    end else if (page_wr || page_rd) begin
      next_page_addr = page_addr + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      init_a <= efr_pkg::ZERO_RESET;
      init_b <= efr_pkg::ZERO_RESET;
      trees <= '0;
      sm_rate <= efr_pkg::SM_RATE_RESET;
      cl_rate <= efr_pkg::CL_RATE_RESET;
      page_sel <= efr_pkg::ZERO_RESET;
      page_mode <= efr_pkg::ZERO_RESET;
      bank_gate <= efr_pkg::ZERO_RESET;
      page_addr <= efr_pkg::ZERO_RESET;
    end else begin
      init_a <= next_init_a;
      init_b <= next_init_b;
      trees <= next_trees;
      sm_rate <= next_sm_rate;
      cl_rate <= next_cl_rate;
      page_sel <= next_page_sel;
      page_mode <= next_page_mode;
      bank_gate <= next_bank_gate;
      page_addr <= next_page_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe
  always_comb begin
    next_rdata = rdata;
    next_enable_seen = embedded_features_on;
    if (reg_read) begin
      next_rdata = 8'h00;
      if (reg_addr == efr_pkg::OFS_BANK_GATE) begin
        next_rdata = bank_gate;
      end else if (bank_open) begin
        case (reg_addr)
          efr_pkg::OFS_EVENT_SOURCE: next_rdata = src_view;
          efr_pkg::OFS_INIT_A: next_rdata = init_a;
          efr_pkg::OFS_INIT_B: next_rdata = init_b;
          efr_pkg::OFS_TREE_1: next_rdata = trees[7:0];
          efr_pkg::OFS_TREE_2: next_rdata = trees[15:8];
          efr_pkg::OFS_TREE_3: next_rdata = trees[23:16];
          efr_pkg::OFS_TREE_4: next_rdata = trees[31:24];
          efr_pkg::OFS_SM_RATE: next_rdata = sm_rate;
          efr_pkg::OFS_CL_RATE: next_rdata = cl_rate;
          efr_pkg::OFS_PAGE_SELECT: next_rdata = page_sel;
          efr_pkg::OFS_PAGE_MODE: next_rdata = page_mode;
          efr_pkg::OFS_PAGE_ADDRESS: next_rdata = page_addr;
          efr_pkg::OFS_PAGE_VALUE: begin
            next_rdata = page_rd ? page_rdata : 8'h00;
          end
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      enable_seen <= 1'b0;
    end else begin
      rdata <= next_rdata;
      enable_seen <= next_enable_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata;
  assign step_count = step_cnt[efr_pkg::STEP_COUNT_W-1:0];
  assign feature_bank_open = bank_open;
  assign early_classifier_reinit = init_a[efr_pkg::INIT_EARLY_BIT];
  assign significant_motion_reinit = init_a[efr_pkg::INIT_SIGMOT_BIT];
  assign tilt_reinit = init_a[efr_pkg::INIT_TILT_BIT];
  assign stride_algo_reinit = init_a[efr_pkg::INIT_STRIDE_BIT];
  assign late_classifier_reinit = init_b[efr_pkg::INIT_LATE_BIT];
  assign state_program_reinit = init_b[efr_pkg::INIT_PROGRAM_BIT];
  assign state_program_rate_dhz = rate_dhz(sm_rate[efr_pkg::SM_CODE_LSB +: 3],
                                           efr_pkg::SM_NORMAL_MAX,
                                           biopotential_only, high_perf_select);
  assign classifier_rate_dhz = rate_dhz(cl_rate[efr_pkg::CL_CODE_LSB +: 3],
                                        efr_pkg::CL_NORMAL_MAX,
                                        biopotential_only, high_perf_select);

endmodule

// [rtl/efr_pkg.sv]
// Constants for the embedded function register bank.
// Assumes an 8-bit address, 8-bit data register port inside the sensor.
package efr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Main bank offsets
  localparam logic [7:0] OFS_PAGE_SELECT = 8'h02;
  localparam logic [7:0] OFS_PAGE_ADDRESS = 8'h08;
  localparam logic [7:0] OFS_PAGE_VALUE = 8'h09;
  localparam logic [7:0] OFS_PAGE_MODE = 8'h17;
  localparam logic [7:0] OFS_EVENT_SOURCE = 8'h2A;
  localparam logic [7:0] OFS_INIT_A = 8'h2C;
  localparam logic [7:0] OFS_INIT_B = 8'h2D;
  localparam logic [7:0] OFS_TREE_1 = 8'h34;
  localparam logic [7:0] OFS_TREE_2 = 8'h35;
  localparam logic [7:0] OFS_TREE_3 = 8'h36;
  localparam logic [7:0] OFS_TREE_4 = 8'h37;
  localparam logic [7:0] OFS_SM_RATE = 8'h39;
  localparam logic [7:0] OFS_CL_RATE = 8'h3A;
  localparam logic [7:0] OFS_BANK_GATE = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SRC_CLEAR_BIT = 7;
  localparam int SRC_DETECT_BIT = 5;
  localparam int SRC_WINDOW_BIT = 4;
  localparam int SRC_OVF_BIT = 3;
  localparam int SRC_INCR_BIT = 2;
  localparam int INIT_EARLY_BIT = 7;
  localparam int INIT_SIGMOT_BIT = 5;
  localparam int INIT_TILT_BIT = 4;
  localparam int INIT_STRIDE_BIT = 3;
  localparam int INIT_LATE_BIT = 4;
  localparam int INIT_PROGRAM_BIT = 0;
  localparam int SM_CODE_LSB = 3;
  localparam int CL_CODE_LSB = 4;
  localparam int MODE_READ_BIT = 5;
  localparam int MODE_WRITE_BIT = 6;
  localparam int BANK_OPEN_BIT = 7;

  // Writable bits per register; everything else reads zero
  localparam logic [7:0] INIT_A_MASK = 8'hB8;
  localparam logic [7:0] INIT_B_MASK = 8'h11;
  localparam logic [7:0] SM_RATE_MASK = 8'h78;
  localparam logic [7:0] CL_RATE_MASK = 8'h71;
  localparam logic [7:0] PAGE_SEL_MASK = 8'h0F;
  localparam logic [7:0] PAGE_MODE_MASK = 8'h60;
  localparam logic [7:0] BANK_GATE_MASK = 8'h80;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] SM_RATE_RESET = 8'h48;
  localparam logic [7:0] CL_RATE_RESET = 8'h11;
  localparam logic [7:0] ZERO_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Rates in tenths of a hertz
  localparam logic [15:0] NORMAL_BASE_DHZ = 16'h007D;
  localparam logic [15:0] BIO_BASE_DHZ = 16'h01F4;
  localparam logic [2:0] SM_NORMAL_MAX = 3'h6;
  localparam logic [2:0] CL_NORMAL_MAX = 3'h4;
  localparam logic [2:0] BIO_TOP_CODE = 3'h5;
  localparam int STEP_COUNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Advanced-feature page 0
  localparam logic [3:0] PAGE_ZERO = 4'h0;
  localparam int PAGE0_COUNT = 12;
  localparam logic [7:0] PAGE0_ADDR [PAGE0_COUNT] = '{
    8'h54, 8'h55, 8'h56, 8'h58, 8'h59, 8'h5D,
    8'h5E, 8'hAA, 8'hAB, 8'hB6, 8'hB7, 8'hD2};
  localparam logic [7:0] PAGE0_RESET [PAGE0_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h0A, 8'h00, 8'h00, 8'h66, 8'h12, 8'h00};
  localparam int PAGE0_WINDOW_LO = 7;
  localparam int PAGE0_WINDOW_HI = 8;

endpackage

// [rtl/efr_page0_store.sv]
// Advanced-feature page 0 storage: twelve bytes at sparse addresses.
// Assumes the caller has already checked page, mode and enables.
module efr_page0_store (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [efr_pkg::PAGE0_COUNT*8-1:0] config_flat
);

  logic [7:0] store [efr_pkg::PAGE0_COUNT];
  logic [7:0] next_store [efr_pkg::PAGE0_COUNT];

  // Reserved holes are never written, so they cannot be corrupted
  function automatic logic hit_at(input logic [7:0] a, input int i);
    hit_at = (a == efr_pkg::PAGE0_ADDR[i]);
  endfunction

  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < efr_pkg::PAGE0_COUNT; i++) begin
      next_store[i] = store[i];
      config_flat[i*8 +: 8] = store[i];
      if (hit_at(addr, i)) begin
        rdata = store[i];
      end
      if (load) begin
        next_store[i] = efr_pkg::PAGE0_RESET[i];
      end else if (wr_en && hit_at(addr, i)) begin
        next_store[i] = wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < efr_pkg::PAGE0_COUNT; i++) begin
      if (!reset_n) begin
        store[i] <= efr_pkg::PAGE0_RESET[i];
      end else begin
        store[i] <= next_store[i];
      end
    end
  end

endmodule

// [tb/efr_host.sv]
// Host model of the register port: byte writes, reads and paged access.
// Assumes one-cycle strobes and read data held from the edge after a read.
module efr_host (
  input wire logic clock,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_read = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////
  // Only listed page 0 bytes are ever written
  task automatic pwrite(input logic [7:0] a, input logic [7:0] d);
    wr(8'h3F, 8'h80);
    wr(8'h17, 8'h40);
    wr(8'h02, 8'h00);
    wr(8'h08, a);
    wr(8'h09, d);
    wr(8'h17, 8'h00);
    wr(8'h3F, 8'h00);
  endtask

  // Two value reads, so the address advance is always exercised
  task automatic pread(input logic [7:0] a, output logic [7:0] d0,
                       output logic [7:0] d1);
    wr(8'h3F, 8'h80);
    wr(8'h17, 8'h20);
    wr(8'h02, 8'h00);
    wr(8'h08, a);
    rd(8'h09, d0);
    rd(8'h09, d1);
    wr(8'h17, 8'h00);
    wr(8'h3F, 8'h00);
  endtask
endmodule

// [tb/efr_regs_chk.sv]
// Checker for the embedded function register bank.
// Assumes it is bound to the bank top and sees only its ports.
module efr_regs_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic embedded_features_on,
  input wire logic high_perf_select,
  input wire logic biopotential_only,
  input wire logic algo_update,
  input wire logic stride_count_incr_in,
  input wire logic [efr_pkg::STEP_COUNT_W-1:0] step_count,
  input wire logic feature_bank_open,
  input wire logic [15:0] state_program_rate_dhz,
  input wire logic [15:0] classifier_rate_dhz,
  input wire logic [efr_pkg::PAGE0_COUNT*8-1:0] feature_config
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  localparam logic [95:0] PAGE_DEFAULTS = 96'h0012_6600_000A_0000_0000_0000;

  ////////////////////////////////////////////////////////////////
  sequence s_src_write;
    reg_write && reg_addr == efr_pkg::OFS_EVENT_SOURCE;
  endsequence
  sequence s_step_in;
    algo_update && stride_count_incr_in;
  endsequence

  a_clear_zeroes_count: assert property (
    s_src_write ##0 reg_wdata[7] && feature_bank_open |=> step_count == 16'h0000)
    else $error("step count not cleared");
  a_step_adds_one: assert property (
    s_step_in ##0 !reg_write && step_count != 16'hFFFF
    |=> step_count == $past(step_count) + 16'h0001)
    else $error("step count did not advance by one");
  a_count_holds: assert property (
    !algo_update && !reg_write |=> $stable(step_count))
    else $error("step count moved without cause");
  a_gate_follows: assert property (
    reg_write && reg_addr == efr_pkg::OFS_BANK_GATE
    |=> feature_bank_open == $past(reg_wdata[7]))
    else $error("bank gate does not follow write");
  a_read_holds: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_sm_rate_normal: assert property (
    !biopotential_only |-> state_program_rate_dhz inside {16'h0000, 16'h007D,
      16'h00FA, 16'h01F4, 16'h03E8, 16'h07D0, 16'h0FA0, 16'h1F40})
    else $error("normal state program rate off table");
  a_top_rate_gated: assert property (
    high_perf_select |-> state_program_rate_dhz != 16'h3E80
      && classifier_rate_dhz != 16'h3E80)
    else $error("top rate offered with high performance on");
  a_page_reload: assert property (
    $rose(embedded_features_on) |=> feature_config == PAGE_DEFAULTS)
    else $error("page 0 not reloaded on enable");
endmodule

// [tb/testbench.sv]
// Self-checking bench for the embedded function register bank.
// Assumes the host model owns the register port; all else is driven here.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock;
  logic reset_n;
  wire reg_write;
  wire reg_read;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  logic embedded_features_on;
  logic high_perf_select;
  logic biopotential_only;
  logic algo_update;
  logic [2:0] flags;
  logic [31:0] tree_output_in;
  wire [15:0] step_count;
  wire feature_bank_open;
  wire [5:0] init_bits;
  wire [15:0] sm_rate;
  wire [15:0] cl_rate;
  wire [95:0] feature_config;
  int mismatches;
  int check_count;

  efr_embedded_function_regs efr_embedded_function_regs_inst (
    .clock(clock), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .embedded_features_on(embedded_features_on), .high_perf_select(high_perf_select),
    .biopotential_only(biopotential_only), .algo_update(algo_update),
    .step_detected_in(flags[2]), .window_stride_in(flags[1]),
    .stride_count_incr_in(flags[0]), .tree_output_in(tree_output_in),
    .step_count(step_count), .feature_bank_open(feature_bank_open),
    .early_classifier_reinit(init_bits[5]), .significant_motion_reinit(init_bits[4]),
    .tilt_reinit(init_bits[3]), .stride_algo_reinit(init_bits[2]),
    .late_classifier_reinit(init_bits[1]), .state_program_reinit(init_bits[0]),
    .state_program_rate_dhz(sm_rate), .classifier_rate_dhz(cl_rate),
    .feature_config(feature_config));

  efr_host efr_host_inst (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    efr_host_inst.rd(a, d);
    chk(d, e);
  endtask

  task automatic pulse(input logic [2:0] f, input logic [31:0] t);
    @(posedge clock);
    #1;
    algo_update = 1'b1;
    flags = f;
    tree_output_in = t;
    @(posedge clock);
    #1;
    algo_update = 1'b0;
    flags = ~f;
    tree_output_in = ~t;
  endtask

  task automatic set_mode(input logic b, input logic h);
    @(posedge clock);
    #1;
    biopotential_only = b;
    high_perf_select = h;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    efr_host_inst.wr(8'h3F, 8'h80);
    chk(feature_bank_open, 1'b1);
    rdchk(8'h2C, 8'h00);
    rdchk(8'h2D, 8'h00);
    rdchk(8'h39, 8'h48);
    rdchk(8'h3A, 8'h11);
    rdchk(8'h3B, 8'h00);
    chk(sm_rate, 16'h00FA);
    chk(cl_rate, 16'h00FA);
    efr_host_inst.wr(8'h2C, 8'hB8);
    efr_host_inst.wr(8'h2D, 8'h11);
    chk(init_bits, 6'h3F);
    rdchk(8'h2C, 8'hB8);
    rdchk(8'h2D, 8'h11);
    efr_host_inst.wr(8'h2C, 8'h00);
    efr_host_inst.wr(8'h2D, 8'h00);
    chk(init_bits, 6'h00);
  endtask

  task automatic t_rates();
    logic [15:0] e;
    for (int c = 0; c < 7; c++) begin
      efr_host_inst.wr(8'h39, {2'b01, 3'(c), 3'b000});
      efr_host_inst.wr(8'h3A, {1'b0, 3'(c), 4'b0001});
      set_mode(1'b0, 1'b0);
      chk(sm_rate, 16'h007D << c);
      if (c < 5) chk(cl_rate, 16'h007D << c);
      else chk(cl_rate, 16'h0000);
      for (int h = 0; h < 2; h++) begin
        set_mode(1'b1, h[0]);
        e = (c == 6 || (h == 1 && c == 5)) ? 16'h0000 : 16'h01F4 << c;
        chk(sm_rate, e);
        chk(cl_rate, e);
      end
    end
    set_mode(1'b0, 1'b0);
  endtask

  task automatic t_algo();
    logic [31:0] t;
    t = 32'hA1B2C3D4;
    pulse(3'b111, t);
    chk(step_count, 16'h0001);
    rdchk(8'h2A, 8'h34);
    for (int i = 0; i < 4; i++) begin
      rdchk(8'h34 + 8'(i), t[8*i +: 8]);
    end
    efr_host_inst.wr(8'h3F, 8'h00);
    rdchk(8'h35, 8'h00);
    efr_host_inst.wr(8'h3F, 8'h80);
    pulse(3'b000, 32'h0);
    rdchk(8'h2A, 8'h00);
    rdchk(8'h34, 8'h00);
    efr_host_inst.wr(8'h2A, 8'h80);
    chk(step_count, 16'h0000);
    rdchk(8'h2A, 8'h80);
    efr_host_inst.wr(8'h2A, 8'h00);
  endtask

  task automatic t_overflow();
    logic [7:0] d;
    @(posedge clock);
    #1;
    algo_update = 1'b1;
    flags = 3'b001;
    repeat (65535) @(posedge clock);
    #1;
    algo_update = 1'b0;
    chk(step_count, 16'hFFFF);
    efr_host_inst.rd(8'h2A, d);
    chk(d[3], 1'b0);
    pulse(3'b001, 32'h0);
    efr_host_inst.rd(8'h2A, d);
    chk(d[3], 1'b1);
    efr_host_inst.wr(8'h2A, 8'h80);
    efr_host_inst.rd(8'h2A, d);
    chk(d[3], 1'b0);
    efr_host_inst.wr(8'h2A, 8'h00);
    efr_host_inst.pwrite(8'hAA, 8'h01);
    efr_host_inst.wr(8'h3F, 8'h80);
    pulse(3'b001, 32'h0);
    chk(step_count, 16'h0001);
    efr_host_inst.rd(8'h2A, d);
    chk(d[2], 1'b0);
    efr_host_inst.pwrite(8'hAA, 8'h00);
  endtask

  task automatic t_page();
    logic [7:0] d0;
    logic [7:0] d1;
    efr_host_inst.pread(8'hB6, d0, d1);
    chk(d0, 8'h66);
    chk(d1, 8'h12);
    efr_host_inst.pwrite(8'h5E, 8'h06);
    chk(feature_config[55:48], 8'h06);
    efr_host_inst.pread(8'h5D, d0, d1);
    chk(d1, 8'h06);
    efr_host_inst.wr(8'h3F, 8'h80);
    efr_host_inst.wr(8'h17, 8'h20);
    efr_host_inst.wr(8'h02, 8'h01);
    efr_host_inst.wr(8'h08, 8'h5E);
    rdchk(8'h09, 8'h00);
    efr_host_inst.wr(8'h02, 8'h00);
    rdchk(8'h09, 8'h06);
    @(posedge clock);
    #1;
    embedded_features_on = 1'b0;
    rdchk(8'h09, 8'h00);
    embedded_features_on = 1'b1;
    @(posedge clock);
    #1;
    chk(feature_config[55:48], 8'h0A);
    efr_host_inst.wr(8'h17, 8'h00);
    efr_host_inst.wr(8'h3F, 8'h00);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    embedded_features_on = 1'b1;
    high_perf_select = 1'b0;
    biopotential_only = 1'b0;
    algo_update = 1'b0;
    flags = 3'b000;
    tree_output_in = 32'h0;
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_defaults();
    t_rates();
    t_algo();
    t_overflow();
    t_page();
    complete_run();
  end

  // Hang guard well beyond the longest run
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    complete_run();
  end
endmodule

bind efr_embedded_function_regs efr_regs_chk efr_regs_chk_inst (.clock, .reset_n,
  .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .embedded_features_on,
  .high_perf_select, .biopotential_only, .algo_update, .stride_count_incr_in,
  .step_count, .feature_bank_open, .state_program_rate_dhz, .classifier_rate_dhz,
  .feature_config);
